// ===== qacr_pkg.sv
// shared constants and types for the four-axis encoder counter
// assumes a single 20 MHz system clock and synchronous reset
package qacr_pkg;

   // ==========================================================
   // register selects within an axis (three select pins)
   localparam logic [2:0] QACR_REG_MASK  = 3'h0;
   localparam logic [2:0] QACR_REG_CSET  = 3'h1;
   localparam logic [2:0] QACR_REG_FSET  = 3'h2;
   localparam logic [2:0] QACR_REG_STAT  = 3'h3;
   localparam logic [2:0] QACR_REG_BYTE0 = 3'h4;
   localparam logic [2:0] QACR_REG_BYTE1 = 3'h5;
   localparam logic [2:0] QACR_REG_BYTE2 = 3'h6;
   localparam logic [2:0] QACR_REG_CMD   = 3'h7;

   // ==========================================================
   // command bit positions
   localparam int QACR_CMD_RST_CNT  = 0;
   localparam int QACR_CMD_LOAD_CNT = 1;
   localparam int QACR_CMD_SNAP     = 2;
   localparam int QACR_CMD_CLR_STAT = 3;
   localparam int QACR_CMD_MASTER   = 4;
   localparam int QACR_CMD_SET_SIGN = 5;
   localparam int QACR_CMD_CLR_SIGN = 6;
   localparam int QACR_CMD_CLR_PEND = 7;

   // ==========================================================
   // count setup fields and codes
   localparam logic [1:0] QACR_TYPE_PLAIN = 2'h0;
   localparam logic [1:0] QACR_TYPE_X1    = 2'h1;
   localparam logic [1:0] QACR_TYPE_X2    = 2'h2;
   localparam logic [1:0] QACR_TYPE_X4    = 2'h3;
   localparam logic [1:0] QACR_MODE_FREE  = 2'h0;
   localparam logic [1:0] QACR_MODE_ONCE  = 2'h1;
   localparam logic [1:0] QACR_MODE_RANGE = 2'h2;
   localparam logic [1:0] QACR_MODE_MODN  = 2'h3;
   localparam logic [1:0] QACR_IDX_OFF    = 2'h0;
   localparam logic [1:0] QACR_IDX_LOAD   = 2'h1;
   localparam logic [1:0] QACR_IDX_RESET  = 2'h2;
   localparam logic [1:0] QACR_IDX_SNAP   = 2'h3;
   localparam int QACR_CSET_IDX_POL = 6;
   // flag setup bit positions
   localparam int QACR_FSET_NOCOUNT = 6;
   localparam int QACR_FSET_DIRECT  = 7;
   localparam logic [1:0] QACR_FB_SIGN = 2'h1;
   localparam logic [1:0] QACR_FB_DIR  = 2'h2;

   // ==========================================================
   // widths, limits and values after reset
   localparam int QACR_AXES = 4;
   localparam logic [23:0] QACR_CNT_MAX  = 24'hffffff;
   localparam logic [23:0] QACR_CNT_ZERO = 24'h000000;
   localparam logic [7:0]  QACR_BYTE_RST = 8'h00;
   localparam logic [3:0]  QACR_NIB_RST  = 4'h0;

   // ==========================================================
   // bus front end states, gray coded
   typedef enum logic [1:0] {
      QACR_IDLE  = 2'b00,
      QACR_ARMED = 2'b01,
      QACR_FIRE  = 2'b11
   } qacr_bus_st_t;

   typedef struct packed {
      logic [7:0]  cset;
      logic [7:0]  fset;
      logic [23:0] load;
      logic [23:0] cnt;
      logic [23:0] snap;
      logic        ovf;
      logic        unf;
      logic        cmp;
      logic        idx;
      logic        sign;
      logic        dir;
      logic        stop;
      logic        fl;
      logic        fa;
      logic        fb;
      logic        a;
      logic        b;
      logic        ix;
   } qacr_axis_t;

endpackage

// ===== qacr_bus_if.sv
// carrier between the parallel bus front end and the counter core
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface qacr_bus_if;
   logic       wr_stb;
   logic [1:0] wr_axis;
   logic [2:0] wr_reg;
   logic [7:0] wr_data;
   logic [1:0] rd_axis;
   logic [2:0] rd_reg;
   logic [7:0] rd_data;

   modport front (output wr_stb, wr_axis, wr_reg, wr_data,
                  output rd_axis, rd_reg, input rd_data);
   modport core  (input wr_stb, wr_axis, wr_reg, wr_data,
                  input rd_axis, rd_reg, output rd_data);
endinterface

// ===== qacr_bus.sv
// octal parallel bus front end: write strobe and read data flop
// assumes bus pins already synchronous to the system clock
`timescale 1ns/1ps
module qacr_bus
(
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_in,
   // host pins
   input  wire logic       cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic [2:0] reg_sel_in,
   input  wire logic [1:0] axis_sel_in,
   input  wire logic [7:0] db_in,
   output logic [7:0]      db_out,
   output logic            db_oe_out,
   // core side
   qacr_bus_if.front       bus
);

   typedef struct packed {
      qacr_pkg::qacr_bus_st_t st;
      logic [1:0]             axis;
      logic [2:0]             rsel;
      logic [7:0]             data;
      logic [7:0]             dout;
   } qacr_bus_state_t;

   qacr_bus_state_t s_r;
   qacr_bus_state_t s_nxt;

   // ==========================================================
   // write completes at trailing edge of the strobe
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.dout = bus.rd_data;
      case (s_r.st)
         qacr_pkg::QACR_IDLE:
         begin
            if (!cs_n_in && !wr_n_in && rd_n_in)
            begin
               s_nxt.st = qacr_pkg::QACR_ARMED;
            end
         end
         qacr_pkg::QACR_ARMED:
         begin
            // keep sampling while low: data settles late
            s_nxt.axis = axis_sel_in;
            s_nxt.rsel = reg_sel_in;
            s_nxt.data = db_in;
            if (wr_n_in)
            begin
               s_nxt.st = cs_n_in ? qacr_pkg::QACR_IDLE
                                  : qacr_pkg::QACR_FIRE;
            end
         end
         qacr_pkg::QACR_FIRE:
         begin
            s_nxt.st = qacr_pkg::QACR_IDLE;
         end
         default:
         begin
            s_nxt.st = qacr_pkg::QACR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign bus.wr_stb  = (s_r.st == qacr_pkg::QACR_FIRE);
   assign bus.wr_axis = s_r.axis;
   assign bus.wr_reg  = s_r.rsel;
   assign bus.wr_data = s_r.data;
   assign bus.rd_axis = axis_sel_in;
   assign bus.rd_reg  = reg_sel_in;
   assign db_out      = s_r.dout;
   assign db_oe_out   = !cs_n_in && !rd_n_in && wr_n_in;

endmodule // qacr_bus

// ===== qacr_top.sv
// four-axis 24-bit encoder counter with status and interrupt logic
// assumes encoder and bus inputs are synchronous to clk_sys_in
//
// Functional notes
// - four identical axes, each with own 24-bit counter and registers
// - load value written as three write-only bytes, never read back
// - counter preset only by transfer from load value holder
// - load value is modulo-n top count (n is value plus one) or upper range limit
// - counter constantly compared with load value, can drive flag
// - quadrature counts from A and B; plain mode counts A pulses
// - free, single-cycle, modulo-n and range-limit count modes
// - snapshot copies live count without disturbing counting
// - status event bits sticky until cleared, zero after reset
// - status clear spares direction and enable bits
// - carry bit7, borrow bit6, match bit5, index bit4
// - global 4-bit mask, one enable bit per axis
// - mask write takes low nibble, upper nibble ignored
// - mask read returns mask low nibble, pending high nibble
// - pending bit set when axis flag A goes low
// - pending cleared only by own axis command, zero after reset
// - count type: plain, x1, x2, x4 quadrature
// - count mode codes; modulo wraps at holder and zero
// - command bit3 clears carry, borrow, match and index bits
// - command bit7 clears that axis pending bit
`timescale 1ns/1ps
module qacr_top
(
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_in,
   // host bus
   input  wire logic       cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic [2:0] reg_sel_in,
   input  wire logic [1:0] axis_sel_in,
   input  wire logic [7:0] db_in,
   output logic [7:0]      db_out,
   output logic            db_oe_out,
   // encoders
   input  wire logic [3:0] enc_a_in,
   input  wire logic [3:0] enc_b_in,
   input  wire logic [3:0] index_in,
   // flags and interrupt
   output logic [3:0]      event_a_n_out,
   output logic [3:0]      flag_b_out,
   output logic            irq_out
);

   typedef struct packed {
      qacr_pkg::qacr_axis_t [3:0] ax;
      logic [3:0]                 mask;
      logic [3:0]                 pend;
      logic                       irq;
   } qacr_core_t;

   qacr_core_t s_r;
   qacr_core_t s_nxt;
   logic [7:0] rd_mux;

   qacr_bus_if bus ();

   qacr_bus u_bus
   (
      .clk_sys_in  (clk_sys_in),
      .rst_in      (rst_in),
      .cs_n_in     (cs_n_in),
      .rd_n_in     (rd_n_in),
      .wr_n_in     (wr_n_in),
      .reg_sel_in  (reg_sel_in),
      .axis_sel_in (axis_sel_in),
      .db_in       (db_in),
      .db_out      (db_out),
      .db_oe_out   (db_oe_out),
      .bus         (bus)
   );

   // ==========================================================
   // status byte of one axis
   function automatic logic [7:0] qacr_stat(qacr_pkg::qacr_axis_t x);
      logic en;
      en = !x.fset[qacr_pkg::QACR_FSET_NOCOUNT] && !x.stop;
      return {x.ovf, x.unf, x.cmp, x.idx, en, 1'b0, x.dir, x.sign};
   endfunction

   // count pulse and direction from encoder edges
   function automatic logic [1:0] qacr_step(logic [1:0] typ,
      logic pa, logic pb, logic ca, logic cb);
      logic ev;
      logic up;
      ev = 1'b0;
      up = ca ^ pb;
      case (typ)
         qacr_pkg::QACR_TYPE_PLAIN:
         begin
            ev = ca && !pa;
            up = cb;
         end
         qacr_pkg::QACR_TYPE_X1:
         begin
            ev = ca && !pa;
         end
         qacr_pkg::QACR_TYPE_X2:
         begin
            ev = ca ^ pa;
         end
         qacr_pkg::QACR_TYPE_X4:
         begin
            ev = (ca ^ pa) || (cb ^ pb);
         end
         default:
         begin
            ev = 1'b0;
         end
      endcase
      return {ev, up};
   endfunction

   // ==========================================================
   // next state of all axes
   always_comb
   begin
      logic       ev;
      logic       up;
      logic       en;
      logic       ixa;
      logic       ixr;
      logic       sel;
      logic       ovf;
      logic       unf;
      logic       mt;
      logic       fev;
      logic [7:0] cmd;
      logic [1:0] mode;
      logic [1:0] ifn;
      ev   = 1'b0;
      up   = 1'b0;
      en   = 1'b0;
      ixa  = 1'b0;
      ixr  = 1'b0;
      sel  = 1'b0;
      ovf  = 1'b0;
      unf  = 1'b0;
      mt   = 1'b0;
      fev  = 1'b0;
      cmd  = qacr_pkg::QACR_BYTE_RST;
      mode = qacr_pkg::QACR_MODE_FREE;
      ifn  = qacr_pkg::QACR_IDX_OFF;
      s_nxt = s_r;
      if (bus.wr_stb && bus.wr_reg == qacr_pkg::QACR_REG_MASK)
      begin
         s_nxt.mask = bus.wr_data[3:0];
      end
      for (int i = 0; i < qacr_pkg::QACR_AXES; i++)
      begin
         sel = bus.wr_stb && (bus.wr_axis == i[1:0]);
         cmd = (sel && bus.wr_reg == qacr_pkg::QACR_REG_CMD)
               ? bus.wr_data : qacr_pkg::QACR_BYTE_RST;
         mode = s_r.ax[i].cset[3:2];
         ifn  = s_r.ax[i].cset[5:4];
         {ev, up} = qacr_step(s_r.ax[i].cset[1:0], s_r.ax[i].a,
                              s_r.ax[i].b, enc_a_in[i], enc_b_in[i]);
         s_nxt.ax[i].a = enc_a_in[i];
         s_nxt.ax[i].b = enc_b_in[i];
         ixa = s_r.ax[i].cset[qacr_pkg::QACR_CSET_IDX_POL]
               ? index_in[i] : !index_in[i];
         ixr = ixa && !s_r.ax[i].ix;
         s_nxt.ax[i].ix = ixa;
         en = !s_r.ax[i].fset[qacr_pkg::QACR_FSET_NOCOUNT]
              && !s_r.ax[i].stop;
         mt = (s_r.ax[i].cnt == s_r.ax[i].load);
         ovf = 1'b0;
         unf = 1'b0;
         if (ev)
         begin
            s_nxt.ax[i].dir = up;
         end
         if (ev && en && up)
         begin
            if (mode == qacr_pkg::QACR_MODE_RANGE && mt)
            begin
               ovf = 1'b1;
            end
            else if (mode == qacr_pkg::QACR_MODE_MODN && mt)
            begin
               s_nxt.ax[i].cnt = qacr_pkg::QACR_CNT_ZERO;
               ovf = 1'b1;
            end
            else
            begin
               s_nxt.ax[i].cnt = s_r.ax[i].cnt + 24'h000001;
               ovf = (s_r.ax[i].cnt == qacr_pkg::QACR_CNT_MAX);
            end
         end
         else if (ev && en)
         begin
            unf = (s_r.ax[i].cnt == qacr_pkg::QACR_CNT_ZERO);
            if (mode == qacr_pkg::QACR_MODE_RANGE && unf)
            begin
               s_nxt.ax[i].cnt = qacr_pkg::QACR_CNT_ZERO;
            end
            else if (mode == qacr_pkg::QACR_MODE_MODN && unf)
            begin
               s_nxt.ax[i].cnt = s_r.ax[i].load;
            end
            else
            begin
               s_nxt.ax[i].cnt = s_r.ax[i].cnt - 24'h000001;
            end
         end
         // single-cycle stops on wrap until reset or load
         if (mode == qacr_pkg::QACR_MODE_ONCE && (ovf || unf))
         begin
            s_nxt.ax[i].stop = 1'b1;
         end
         if (unf)
         begin
            s_nxt.ax[i].sign = 1'b1;
         end
         else if (ovf)
         begin
            s_nxt.ax[i].sign = 1'b0;
         end
         if (cmd[qacr_pkg::QACR_CMD_SET_SIGN])
         begin
            s_nxt.ax[i].sign = 1'b1;
         end
         if (cmd[qacr_pkg::QACR_CMD_CLR_SIGN])
         begin
            s_nxt.ax[i].sign = 1'b0;
         end
         // command wins over a simultaneous count pulse
         if (cmd[qacr_pkg::QACR_CMD_LOAD_CNT] ||
             (ixr && ifn == qacr_pkg::QACR_IDX_LOAD))
         begin
            s_nxt.ax[i].cnt  = s_r.ax[i].load;
            s_nxt.ax[i].stop = 1'b0;
         end
         else if (cmd[qacr_pkg::QACR_CMD_RST_CNT] ||
                  (ixr && ifn == qacr_pkg::QACR_IDX_RESET))
         begin
            s_nxt.ax[i].cnt  = qacr_pkg::QACR_CNT_ZERO;
            s_nxt.ax[i].sign = 1'b0;
            s_nxt.ax[i].stop = 1'b0;
         end
         if (cmd[qacr_pkg::QACR_CMD_SNAP] ||
             (ixr && ifn == qacr_pkg::QACR_IDX_SNAP))
         begin
            s_nxt.ax[i].snap = s_r.ax[i].cnt;
         end
         // sticky events: clear first, set wins
         if (cmd[qacr_pkg::QACR_CMD_CLR_STAT])
         begin
            s_nxt.ax[i].ovf = 1'b0;
            s_nxt.ax[i].unf = 1'b0;
            s_nxt.ax[i].cmp = 1'b0;
            s_nxt.ax[i].idx = 1'b0;
            s_nxt.ax[i].fl  = 1'b0;
         end
         s_nxt.ax[i].ovf = s_nxt.ax[i].ovf || ovf;
         s_nxt.ax[i].unf = s_nxt.ax[i].unf || unf;
         s_nxt.ax[i].cmp = s_nxt.ax[i].cmp || mt;
         s_nxt.ax[i].idx = s_nxt.ax[i].idx || ixa;
         fev = |({ixa, mt, unf, ovf} & s_r.ax[i].fset[3:0]);
         s_nxt.ax[i].fl = s_nxt.ax[i].fl || fev;
         s_nxt.ax[i].fa = s_r.ax[i].fset[qacr_pkg::QACR_FSET_DIRECT]
                          ? fev : s_nxt.ax[i].fl;
         case (s_r.ax[i].fset[5:4])
            qacr_pkg::QACR_FB_SIGN: s_nxt.ax[i].fb = s_nxt.ax[i].sign;
            qacr_pkg::QACR_FB_DIR:  s_nxt.ax[i].fb = s_nxt.ax[i].dir;
            default:                s_nxt.ax[i].fb = 1'b1;
         endcase
         if (cmd[qacr_pkg::QACR_CMD_CLR_PEND])
         begin
            s_nxt.pend[i] = 1'b0;
         end
         if (s_nxt.ax[i].fa && !s_r.ax[i].fa)
         begin
            s_nxt.pend[i] = 1'b1;
         end
         if (sel && bus.wr_reg == qacr_pkg::QACR_REG_CSET)
         begin
            s_nxt.ax[i].cset = bus.wr_data;
         end
         if (sel && bus.wr_reg == qacr_pkg::QACR_REG_FSET)
         begin
            s_nxt.ax[i].fset = bus.wr_data;
         end
         if (sel && bus.wr_reg == qacr_pkg::QACR_REG_BYTE0)
         begin
            s_nxt.ax[i].load[7:0] = bus.wr_data;
         end
         if (sel && bus.wr_reg == qacr_pkg::QACR_REG_BYTE1)
         begin
            s_nxt.ax[i].load[15:8] = bus.wr_data;
         end
         if (sel && bus.wr_reg == qacr_pkg::QACR_REG_BYTE2)
         begin
            s_nxt.ax[i].load[23:16] = bus.wr_data;
         end
         if (cmd[qacr_pkg::QACR_CMD_MASTER])
         begin
            s_nxt.ax[i]      = '0;
            s_nxt.ax[i].a    = enc_a_in[i];
            s_nxt.ax[i].b    = enc_b_in[i];
            s_nxt.ax[i].ix   = ixa;
            s_nxt.ax[i].fb   = 1'b1;
            s_nxt.pend[i]    = 1'b0;
            s_nxt.mask       = qacr_pkg::QACR_NIB_RST;
         end
      end
      s_nxt.irq = |(s_nxt.pend & s_nxt.mask);
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // read mux; load value holder has no read path
   always_comb
   begin
      case (bus.rd_reg)
         qacr_pkg::QACR_REG_MASK:  rd_mux = {s_r.pend, s_r.mask};
         qacr_pkg::QACR_REG_CSET:  rd_mux = s_r.ax[bus.rd_axis].cset;
         qacr_pkg::QACR_REG_FSET:  rd_mux = s_r.ax[bus.rd_axis].fset;
         qacr_pkg::QACR_REG_STAT:  rd_mux = qacr_stat(s_r.ax[bus.rd_axis]);
         qacr_pkg::QACR_REG_BYTE0: rd_mux = s_r.ax[bus.rd_axis].snap[7:0];
         qacr_pkg::QACR_REG_BYTE1: rd_mux = s_r.ax[bus.rd_axis].snap[15:8];
         qacr_pkg::QACR_REG_BYTE2: rd_mux = s_r.ax[bus.rd_axis].snap[23:16];
         default:                  rd_mux = qacr_pkg::QACR_BYTE_RST;
      endcase
   end

   assign bus.rd_data = rd_mux;

   genvar g;
   generate
      for (g = 0; g < qacr_pkg::QACR_AXES; g++)
      begin : g_out
         assign event_a_n_out[g] = !s_r.ax[g].fa;
         assign flag_b_out[g]    = s_r.ax[g].fb;
      end
   endgenerate
   assign irq_out = s_r.irq;

   // ==========================================================
   // checks on axis 0 and the shared registers
   logic [7:0] stat0;
   assign stat0 = qacr_stat(s_r.ax[0]);

   // boolean helper, so it may be negated and combined in the checks
   function automatic logic cmd0(int b);
      return bus.wr_stb && bus.wr_axis == 2'h0
             && bus.wr_reg == qacr_pkg::QACR_REG_CMD && bus.wr_data[b];
   endfunction

   property p_pend_set;
      @(posedge clk_sys_in) disable iff (rst_in)
      $fell(event_a_n_out[0]) |-> s_r.pend[0];
   endproperty
   a_pend_set: assert property (p_pend_set)
      else $error("pending not set on flag fall");

   property p_pend_hold;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_r.pend[0] && !(bus.wr_stb && bus.wr_axis == 2'h0
         && bus.wr_reg == qacr_pkg::QACR_REG_CMD)
      |=> s_r.pend[0];
   endproperty
   a_pend_hold: assert property (p_pend_hold)
      else $error("pending bit lost without own command");

   property p_irq;
      @(posedge clk_sys_in) disable iff (rst_in)
      (|(s_r.pend & s_r.mask)) == irq_out;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt disagrees with pending and mask");

   property p_mask_wr;
      @(posedge clk_sys_in) disable iff (rst_in)
      bus.wr_stb && bus.wr_reg == qacr_pkg::QACR_REG_MASK
      |=> s_r.mask == $past(bus.wr_data[3:0]);
   endproperty
   a_mask_wr: assert property (p_mask_wr)
      else $error("mask write not taken");

   property p_mask_rd;
      @(posedge clk_sys_in) disable iff (rst_in)
      bus.rd_reg == qacr_pkg::QACR_REG_MASK
      |=> db_out == {$past(s_r.pend), $past(s_r.mask)};
   endproperty
   a_mask_rd: assert property (p_mask_rd)
      else $error("joint mask read wrong");

   property p_snap;
      @(posedge clk_sys_in) disable iff (rst_in)
      cmd0(qacr_pkg::QACR_CMD_SNAP) && !cmd0(qacr_pkg::QACR_CMD_MASTER)
      |=> s_r.ax[0].snap == $past(s_r.ax[0].cnt);
   endproperty
   a_snap: assert property (p_snap)
      else $error("snapshot not taken");

   property p_load;
      @(posedge clk_sys_in) disable iff (rst_in)
      cmd0(qacr_pkg::QACR_CMD_LOAD_CNT) && !cmd0(qacr_pkg::QACR_CMD_MASTER)
      |=> s_r.ax[0].cnt == $past(s_r.ax[0].load);
   endproperty
   a_load: assert property (p_load)
      else $error("counter not loaded from holder");

   property p_sticky;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_r.ax[0].ovf && !cmd0(qacr_pkg::QACR_CMD_CLR_STAT)
      && !cmd0(qacr_pkg::QACR_CMD_MASTER) |=> s_r.ax[0].ovf;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("carry bit not sticky");

   property p_stat_fix;
      @(posedge clk_sys_in) disable iff (rst_in)
      !stat0[2] && (stat0[3] ==
      !(s_r.ax[0].fset[qacr_pkg::QACR_FSET_NOCOUNT] || s_r.ax[0].stop));
   endproperty
   a_stat_fix: assert property (p_stat_fix)
      else $error("status enable or zero bit wrong");

endmodule // qacr_top

// ===== qacr_host.sv
// host processor model driving the octal parallel bus
// assumes bus pins sampled on rising clk_sys_in
`timescale 1ns/1ps
module qacr_host
(
   // clock
   input  wire logic       clk_sys_in,
   // bus pins
   output logic            cs_n_out,
   output logic            rd_n_out,
   output logic            wr_n_out,
   output logic [2:0]      reg_sel_out,
   output logic [1:0]      axis_sel_out,
   output logic [7:0]      db_out,
   input  wire logic [7:0] db_in
);
   // ==========================================
   // idle bus; released data shows inverse
   initial
   begin
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      reg_sel_out = 3'h0;
      axis_sel_out = 2'h0;
      db_out = 8'h00;
   end
   // ==========================================
   // write: low one edge, high seen with cs low
   task automatic wr(input logic [1:0] ax, input logic [2:0] rg,
                     input logic [7:0] d);
      @(posedge clk_sys_in);
      cs_n_out <= 1'b0;
      wr_n_out <= 1'b0;
      axis_sel_out <= ax;
      reg_sel_out <= rg;
      db_out <= d;
      @(posedge clk_sys_in);
      wr_n_out <= 1'b1;
      @(posedge clk_sys_in);
      cs_n_out <= 1'b1;
      db_out <= ~d;
      repeat (2) @(posedge clk_sys_in);
   endtask
   // read data is one edge behind the address
   task automatic rd(input logic [1:0] ax, input logic [2:0] rg,
                     output logic [7:0] d);
      @(posedge clk_sys_in);
      cs_n_out <= 1'b0;
      rd_n_out <= 1'b0;
      axis_sel_out <= ax;
      reg_sel_out <= rg;
      repeat (2) @(posedge clk_sys_in);
      d = db_in;
      cs_n_out <= 1'b1;
      rd_n_out <= 1'b1;
   endtask
endmodule // qacr_host

// ===== tb.sv
// self-checking bench for the four-axis counter
// assumes qacr_host drives the bus, bench drives encoders
`timescale 1ns/1ps
module tb;
   logic clk_sys_in, rst_in, cs_n_in, rd_n_in, wr_n_in, irq_out, db_oe_out;
   logic [2:0] reg_sel_in;
   logic [1:0] axis_sel_in, k, t;
   logic [7:0] db_in, db_out, r;
   logic [3:0] enc_a_in, enc_b_in, index_in, event_a_n_out, flag_b_out, m;
   logic [23:0] v, g;
   int n_errors, n_tests, cyc, n;
   qacr_host i_qacr_host(.clk_sys_in, .cs_n_out(cs_n_in),
      .rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .reg_sel_out(reg_sel_in),
      .axis_sel_out(axis_sel_in), .db_out(db_in), .db_in(db_out));
   qacr_top i_qacr_top(.clk_sys_in, .rst_in, .cs_n_in, .rd_n_in,
      .wr_n_in, .reg_sel_in, .axis_sel_in, .db_in, .db_out,
      .db_oe_out, .enc_a_in, .enc_b_in, .index_in,
      .event_a_n_out, .flag_b_out, .irq_out);
   // ==========================================
   // checking and closing
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e)
      begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic stop_test;
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   function automatic logic [7:0] mr(input logic [3:0] p, mk);
      return {p, mk};
   endfunction
   // count after s up steps that start at the holder value
   function automatic logic [23:0] mdx(input int md, input logic [23:0] l,
                                       input int s);
      if (md == 1)
         return 24'h000000;
      if (md == 2)
         return l;
      if (md == 3)
         return 24'((l + 24'(s)) % (l + 24'h000001));
      return l + 24'(s);
   endfunction
   // ==========================================
   // helpers
   task automatic ld(input logic [1:0] a, input logic [23:0] d);
      i_qacr_host.wr(a, 3'h4, d[7:0]);
      i_qacr_host.wr(a, 3'h5, d[15:8]);
      i_qacr_host.wr(a, 3'h6, d[23:16]);
      i_qacr_host.wr(a, 3'h7, 8'h02);
   endtask
   task automatic snap(input logic [1:0] a, input logic [23:0] e);
      i_qacr_host.wr(a, 3'h7, 8'h04);
      i_qacr_host.rd(a, 3'h4, g[7:0]);
      i_qacr_host.rd(a, 3'h5, g[15:8]);
      i_qacr_host.rd(a, 3'h6, g[23:16]);
      for (int i = 0; i < 3; i++) chk(g[i*8+:8], e[i*8+:8]);
   endtask
   // plain mode: count on a rise, b high means up
   task automatic pulse(input logic [1:0] a, input int c);
      repeat (c)
      begin
         @(posedge clk_sys_in) enc_a_in[a] <= 1'b1;
         repeat (2) @(posedge clk_sys_in);
         enc_a_in[a] <= 1'b0;
         repeat (2) @(posedge clk_sys_in);
      end
   endtask
   // quadrature: one forward cycle from a low, b high
   task automatic quad(input logic [1:0] a, input int c);
      repeat (c)
      begin
         @(posedge clk_sys_in) enc_b_in[a] <= 1'b0;
         repeat (2) @(posedge clk_sys_in);
         enc_a_in[a] <= 1'b1;
         repeat (2) @(posedge clk_sys_in);
         enc_b_in[a] <= 1'b1;
         repeat (2) @(posedge clk_sys_in);
         enc_a_in[a] <= 1'b0;
         repeat (2) @(posedge clk_sys_in);
      end
   endtask
   // ==========================================
   initial
   begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   // device drives the bus only while a read is selected
   always @(negedge clk_sys_in)
      if (!cs_n_in)
         chk({7'h0, db_oe_out}, {7'h0, !rd_n_in});
   always @(posedge clk_sys_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         stop_test();
      end
   end
   initial
   begin
      rst_in = 1'b1;
      enc_a_in = 4'h0;
      enc_b_in = 4'hf;
      index_in = 4'hf;
      void'($urandom(17));
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      i_qacr_host.rd(2'h0, 3'h0, r);
      chk(r, 8'h00);
      m = 4'($urandom);
      r = 8'($urandom);
      i_qacr_host.wr(2'($urandom), 3'h0, {r[7:4], m});
      i_qacr_host.rd(2'h3, 3'h0, r);
      chk(r, mr(4'h0, m));
      k = 2'($urandom);
      v = 24'($urandom);
      n = 1 + $urandom % 5;
      ld(k, v);
      pulse(k, n);
      snap(k, v + 24'(n));
      snap(k + 2'h1, 24'h000000);
      i_qacr_host.wr(2'h0, 3'h0, 8'h02);
      i_qacr_host.wr(2'h1, 3'h2, 8'h11);
      ld(2'h1, 24'hffffff);
      pulse(2'h1, 1);
      i_qacr_host.rd(2'h1, 3'h3, r);
      chk(r & 8'h82, 8'h82);
      @(negedge clk_sys_in);
      chk({7'h0, irq_out}, 8'h01);
      chk({4'h0, event_a_n_out}, 8'h0d);
      chk({4'h0, flag_b_out}, 8'h0d);
      i_qacr_host.rd(2'h0, 3'h0, r);
      chk(r, mr(4'h2, 4'h2));
      i_qacr_host.wr(2'h1, 3'h7, 8'h08);
      i_qacr_host.rd(2'h1, 3'h3, r);
      chk(r & 8'hf2, 8'h02);
      chk({4'h0, event_a_n_out}, 8'h0f);
      i_qacr_host.wr(2'h0, 3'h7, 8'h80);
      @(negedge clk_sys_in);
      chk({7'h0, irq_out}, 8'h01);
      i_qacr_host.wr(2'h1, 3'h7, 8'h80);
      @(negedge clk_sys_in);
      chk({7'h0, irq_out}, 8'h00);
      i_qacr_host.rd(2'h2, 3'h0, r);
      chk(r, mr(4'h0, 4'h2));
      for (int md = 0; md < 4; md++)
      begin
         t = 2'(1 + $urandom % 3);
         v = (md == 1) ? 24'hffffff : 24'(2 + $urandom % 8);
         n = 1 + $urandom % 3;
         i_qacr_host.wr(2'h2, 3'h1, {4'h0, 2'(md), t});
         ld(2'h2, v);
         quad(2'h2, n);
         n = n * ((t == 2'h3) ? 4 : int'(t));
         snap(2'h2, mdx(md, v, n));
      end
      @(posedge clk_sys_in) index_in[3] <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      index_in[3] <= 1'b1;
      i_qacr_host.rd(2'h3, 3'h3, r);
      chk(r & 8'h10, 8'h10);
      stop_test();
   end
endmodule // tb
